// File: rtc_alarm_top.sv
// RTC calendar, alarm, tick and seconds counter with AHB-Lite register slave
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_top
    import rtc_alarm_pkg::*;
#(
    parameter int SNAP_CYC = SNAP_HOLD_CYCLES,
    parameter int SEC_CYC  = SEC_CYCLES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq
);
    // Address phase capture
    logic       wr_pend_reg;
    logic       wr_pend_next;
    logic [7:0] wr_idx_reg;
    logic [7:0] wr_idx_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic       rd_take;
    logic       addr_take;
    logic [7:0] a_idx;
    logic       a_ok;

    // Calendar state: running, staged, snapshot
    logic [5:0] sec_reg, min_reg, year_reg;
    logic [4:0] hour_reg, day_reg;
    logic [3:0] mon_reg;
    logic [5:0] sec_next, min_next, year_next;
    logic [4:0] hour_next, day_next;
    logic [3:0] mon_next;
    logic [5:0] st_sec_reg, st_min_reg, st_year_reg;
    logic [4:0] st_hour_reg, st_day_reg;
    logic [3:0] st_mon_reg;
    logic       st_ok_reg, ok_reg;
    logic [5:0] st_sec_next, st_min_next, st_year_next;
    logic [4:0] st_hour_next, st_day_next;
    logic [3:0] st_mon_next;
    logic       st_ok_next, ok_next;
    logic [39:0] cal_snap_reg, cal_snap_next;
    logic [31:0] cal_hold_reg, cal_hold_next;

    // Alarm staged and committed
    logic [7:0] am_reg, ah_reg, ad_reg, amo_reg, ay_reg;
    logic [7:0] am_next, ah_next, ad_next, amo_next, ay_next;
    logic [7:0] cm_reg, ch_reg, cd_reg, cmo_reg, cy_reg;
    logic [7:0] cm_next, ch_next, cd_next, cmo_next, cy_next;

    // Seconds counter and snapshot
    logic [31:0] cnt_reg, cnt_next;
    logic [31:0] cnt_snap_reg, cnt_snap_next;
    logic [31:0] cnt_hold_reg, cnt_hold_next;

    // Interrupt status and mask
    logic [EV_W-1:0] stat_reg, stat_next;
    logic [EV_W-1:0] mask_reg, mask_next;
    logic [EV_W-1:0] events;

    logic sec_pulse, min_pulse, cal_load, alarm_hit, alarm_arm_reg, alarm_arm_next;
    logic [7:0] wb;

    function automatic logic [7:0] rd_mux(input logic [7:0] idx, input logic [39:0] cs,
                                          input logic [31:0] sn);
        logic [7:0] v;
        v = 8'h0;
        case (idx)
            IDX_CAL_SEC:   v = cs[7:0];
            IDX_CAL_MIN:   v = cs[15:8];
            IDX_CAL_HOUR:  v = cs[23:16];
            IDX_CAL_DAY:   v = cs[31:24];
            IDX_CAL_MONTH: v = cs[39:32];
            IDX_SEC_B0:    v = sn[7:0];
            IDX_SEC_B1:    v = sn[15:8];
            IDX_SEC_B2:    v = sn[23:16];
            IDX_SEC_B3:    v = sn[31:24];
            default:       v = 8'h0;
        endcase
        return v;
    endfunction

    rtc_second_timer #(
        .SEC_CYC(SEC_CYC)
    ) u_timer (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .restart  (cal_load),
        .sec_pulse(sec_pulse),
        .min_pulse(min_pulse)
    );

    assign addr_take = hsel && hready && htrans[1];
    assign a_idx     = haddr[ADDR_LSB +: 8];
    assign a_ok      = (haddr[31:ADDR_W] == '0);
    assign rd_take   = addr_take && !hwrite && a_ok;
    assign wb        = hwdata[7:0];
    assign cal_load  = wr_pend_reg && (wr_idx_reg == IDX_CAL_YEAR);

    assign alarm_hit = (sec_reg == 6'h0) && (min_reg == cm_reg[5:0])
                     && (hour_reg == ch_reg[4:0]) && (day_reg == cd_reg[4:0])
                     && (mon_reg == cmo_reg[3:0]) && (year_reg == cy_reg[5:0]);

    always_comb begin
        events = '0;
        events[EV_ALARM_BIT] = cy_reg[ALM_ON_BIT] && cm_reg[ALM_SRC_BIT]
                               && alarm_hit && alarm_arm_reg;
        events[EV_SECOND_BIT] = cy_reg[TICK_ON_BIT] && !cm_reg[ALM_SRC_BIT]
                                && !cm_reg[TICK_MIN_BIT] && sec_pulse;
        events[EV_MINUTE_BIT] = cy_reg[TICK_ON_BIT] && !cm_reg[ALM_SRC_BIT]
                                && cm_reg[TICK_MIN_BIT] && min_pulse;
    end

    // Bus slave, write staging and register next values except the running calendar and seconds counter
    always_comb begin
        wr_pend_next = addr_take && hwrite && a_ok;
        wr_idx_next  = a_idx;
        rdata_next   = rdata_reg;
        {st_sec_next, st_min_next, st_hour_next} = {st_sec_reg, st_min_reg, st_hour_reg};
        {st_day_next, st_mon_next, st_year_next} = {st_day_reg, st_mon_reg, st_year_reg};
        st_ok_next   = st_ok_reg;
        {am_next, ah_next, ad_next, amo_next, ay_next} = {am_reg, ah_reg, ad_reg, amo_reg, ay_reg};
        {cm_next, ch_next, cd_next, cmo_next, cy_next} = {cm_reg, ch_reg, cd_reg, cmo_reg, cy_reg};
        mask_next    = mask_reg;
        stat_next    = stat_reg | events;
        cal_snap_next = cal_snap_reg;
        cal_hold_next = (cal_hold_reg != 32'h0) ? cal_hold_reg - 32'h1 : 32'h0;
        cnt_snap_next = cnt_snap_reg;
        cnt_hold_next = (cnt_hold_reg != 32'h0) ? cnt_hold_reg - 32'h1 : 32'h0;
        alarm_arm_next = alarm_hit ? 1'b0 : 1'b1;
        if (rd_take) begin
            rdata_next = {24'h0, rd_mux(a_idx, cal_snap_reg, cnt_snap_reg)};
            if (a_idx == IDX_CAL_SEC) begin
                if (cal_hold_reg == 32'h0) begin
                    cal_snap_next = {4'h0, mon_reg, 3'h0, day_reg, 3'h0, hour_reg,
                                     2'h0, min_reg, 1'b0, ok_reg, sec_reg};
                    cal_hold_next = 32'(SNAP_CYC);
                    rdata_next = {24'h0, 1'b0, ok_reg, sec_reg};
                end
            end else if (a_idx == IDX_CAL_YEAR) begin
                rdata_next = {26'h0, year_reg};
            end else if (a_idx == IDX_SEC_B0 && cnt_hold_reg == 32'h0) begin
                cnt_snap_next = cnt_reg;
                cnt_hold_next = 32'(SNAP_CYC);
                rdata_next = {24'h0, cnt_reg[7:0]};
            end else if (a_idx == IDX_ALM_MIN) begin
                rdata_next = {24'h0, am_reg};
            end else if (a_idx == IDX_ALM_HOUR) begin
                rdata_next = {24'h0, 3'h0, ah_reg[4:0]};
            end else if (a_idx == IDX_ALM_DAY) begin
                rdata_next = {24'h0, 3'h0, ad_reg[4:0]};
            end else if (a_idx == IDX_ALM_MONTH) begin
                rdata_next = {24'h0, 4'h0, amo_reg[3:0]};
            end else if (a_idx == IDX_ALM_YEAR) begin
                rdata_next = {24'h0, ay_reg};
            end else if (a_idx == IDX_IRQ_STATUS) begin
                rdata_next = {29'h0, stat_reg};
            end else if (a_idx == IDX_IRQ_MASK) begin
                rdata_next = {29'h0, mask_reg};
            end
        end else if (addr_take) begin
            rdata_next = 32'h0;
        end
        if (wr_pend_reg) begin
            case (wr_idx_reg)
                IDX_CAL_SEC: begin
                    st_sec_next = wb[5:0];
                    st_ok_next  = wb[CAL_OK_BIT];
                end
                IDX_CAL_MIN:    st_min_next  = wb[5:0];
                IDX_CAL_HOUR:   st_hour_next = wb[4:0];
                IDX_CAL_DAY:    st_day_next  = wb[4:0];
                IDX_CAL_MONTH:  st_mon_next  = wb[3:0];
                IDX_CAL_YEAR:   st_year_next = wb[5:0];
                IDX_ALM_MIN:    am_next  = wb;
                IDX_ALM_HOUR:   ah_next  = {3'h0, wb[4:0]};
                IDX_ALM_DAY:    ad_next  = {3'h0, wb[4:0]};
                IDX_ALM_MONTH:  amo_next = {4'h0, wb[3:0]};
                IDX_ALM_YEAR: begin
                    ay_next  = wb;
                    cm_next  = am_reg;
                    ch_next  = ah_reg;
                    cd_next  = ad_reg;
                    cmo_next = amo_reg;
                    cy_next  = wb;
                end
                IDX_IRQ_STATUS: stat_next = (stat_reg & ~wb[EV_W-1:0]) | events;
                IDX_IRQ_MASK:   mask_next = wb[EV_W-1:0];
                default: ;
            endcase
        end
    end

    // Running calendar and seconds counter
    always_comb begin
        {sec_next, min_next, hour_next} = {sec_reg, min_reg, hour_reg};
        {day_next, mon_next, year_next} = {day_reg, mon_reg, year_reg};
        ok_next  = ok_reg;
        cnt_next = sec_pulse ? cnt_reg + 32'h1 : cnt_reg;
        if (cal_load) begin
            {sec_next, min_next, hour_next} = {st_sec_reg, st_min_reg, st_hour_reg};
            {day_next, mon_next} = {st_day_reg, st_mon_reg};
            year_next = wb[5:0];
            ok_next   = st_ok_reg;
        end else if (sec_pulse) begin
            sec_next = (sec_reg == MAX_SEC) ? 6'h0 : sec_reg + 6'h1;
            if (sec_reg == MAX_SEC) begin
                min_next = (min_reg == MAX_SEC) ? 6'h0 : min_reg + 6'h1;
                if (min_reg == MAX_SEC) begin
                    hour_next = (hour_reg == MAX_HOUR) ? 5'h0 : hour_reg + 5'h1;
                    if (hour_reg == MAX_HOUR) begin
                        day_next = (day_reg == MAX_DAY) ? RST_DAY : day_reg + 5'h1;
                        if (day_reg == MAX_DAY) begin
                            mon_next = (mon_reg == MAX_MONTH) ? RST_MONTH : mon_reg + 4'h1;
                            if (mon_reg == MAX_MONTH) begin
                                year_next = year_reg + 6'h1;
                            end
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 8'h0;
            rdata_reg   <= 32'h0;
            {sec_reg, min_reg, hour_reg, year_reg} <= '0;
            day_reg <= RST_DAY;
            mon_reg <= RST_MONTH;
            ok_reg  <= 1'b0;
            {st_sec_reg, st_min_reg, st_hour_reg, st_year_reg, st_ok_reg} <= '0;
            st_day_reg <= RST_DAY;
            st_mon_reg <= RST_MONTH;
            {am_reg, ah_reg, ad_reg, amo_reg, ay_reg} <= '0;
            {cm_reg, ch_reg, cd_reg, cmo_reg, cy_reg} <= '0;
            cal_snap_reg <= '0;
            cal_hold_reg <= 32'h0;
            cnt_reg      <= 32'h0;
            cnt_snap_reg <= 32'h0;
            cnt_hold_reg <= 32'h0;
            stat_reg     <= '0;
            mask_reg     <= '0;
            alarm_arm_reg <= 1'b1;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_idx_reg  <= wr_idx_next;
            rdata_reg   <= rdata_next;
            {sec_reg, min_reg, hour_reg} <= {sec_next, min_next, hour_next};
            {day_reg, mon_reg, year_reg} <= {day_next, mon_next, year_next};
            ok_reg <= ok_next;
            {st_sec_reg, st_min_reg, st_hour_reg} <= {st_sec_next, st_min_next, st_hour_next};
            {st_day_reg, st_mon_reg, st_year_reg} <= {st_day_next, st_mon_next, st_year_next};
            st_ok_reg <= st_ok_next;
            {am_reg, ah_reg, ad_reg, amo_reg, ay_reg} <= {am_next, ah_next, ad_next, amo_next,
                                                          ay_next};
            {cm_reg, ch_reg, cd_reg, cmo_reg, cy_reg} <= {cm_next, ch_next, cd_next, cmo_next,
                                                          cy_next};
            cal_snap_reg <= cal_snap_next;
            cal_hold_reg <= cal_hold_next;
            cnt_reg      <= cnt_next;
            cnt_snap_reg <= cnt_snap_next;
            cnt_hold_reg <= cnt_hold_next;
            stat_reg     <= stat_next;
            mask_reg     <= mask_next;
            alarm_arm_reg <= alarm_arm_next;
        end
    end

    assign hrdata    = rdata_reg;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = |(stat_reg & mask_reg);
endmodule
`default_nettype wire

// File: rtc_alarm_pkg.sv
// Package: register map, field layout and timing constants of the RTC alarm block
package rtc_alarm_pkg;
    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_CAL_SEC    = 8'h6f;
    localparam logic [7:0] IDX_CAL_MIN    = 8'h70;
    localparam logic [7:0] IDX_CAL_HOUR   = 8'h71;
    localparam logic [7:0] IDX_CAL_DAY    = 8'h72;
    localparam logic [7:0] IDX_CAL_MONTH  = 8'h73;
    localparam logic [7:0] IDX_CAL_YEAR   = 8'h74;
    localparam logic [7:0] IDX_ALM_MIN    = 8'h75;
    localparam logic [7:0] IDX_ALM_HOUR   = 8'h76;
    localparam logic [7:0] IDX_ALM_DAY    = 8'h77;
    localparam logic [7:0] IDX_ALM_MONTH  = 8'h78;
    localparam logic [7:0] IDX_ALM_YEAR   = 8'h79;
    localparam logic [7:0] IDX_SEC_B0     = 8'h7a;
    localparam logic [7:0] IDX_SEC_B1     = 8'h7b;
    localparam logic [7:0] IDX_SEC_B2     = 8'h7c;
    localparam logic [7:0] IDX_SEC_B3     = 8'h7d;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h80;
    localparam logic [7:0] IDX_IRQ_MASK   = 8'h81;
    localparam int         ADDR_LSB       = 2;
    localparam int         ADDR_W         = 10;

    // Field positions
    localparam int ALM_SRC_BIT   = 6;
    localparam int TICK_MIN_BIT  = 7;
    localparam int ALM_ON_BIT    = 6;
    localparam int TICK_ON_BIT   = 7;
    localparam int CAL_OK_BIT    = 6;
    localparam int EV_ALARM_BIT  = 0;
    localparam int EV_SECOND_BIT = 1;
    localparam int EV_MINUTE_BIT = 2;
    localparam int EV_W          = 3;

    // Calendar limits and reset values
    localparam logic [5:0] MAX_SEC   = 6'h3b;
    localparam logic [4:0] MAX_HOUR  = 5'h17;
    localparam logic [4:0] MAX_DAY   = 5'h1f;
    localparam logic [3:0] MAX_MONTH = 4'hc;
    localparam logic [5:0] MAX_YEAR  = 6'h3f;
    localparam logic [4:0] RST_DAY   = 5'h01;
    localparam logic [3:0] RST_MONTH = 4'h1;

    // Timing
    localparam int CLK_HZ           = 10_000_000;
    localparam int SNAP_HOLD_MS     = 500;
    localparam int SNAP_HOLD_CYCLES = CLK_HZ / 1000 * SNAP_HOLD_MS;
    localparam int SEC_CYCLES       = CLK_HZ;
endpackage

// File: rtc_second_timer.sv
// Divider producing one-cycle pulses per second and per minute
`timescale 1ns/1ps
`default_nettype none
module rtc_second_timer
    import rtc_alarm_pkg::*;
#(
    parameter int SEC_CYC = SEC_CYCLES
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic restart,
    output logic      sec_pulse,
    output logic      min_pulse
);
    logic [31:0] div_reg;
    logic [31:0] div_next;
    logic [5:0]  sub_reg;
    logic [5:0]  sub_next;
    logic        wrap;

    assign wrap = (div_reg == 32'(SEC_CYC - 1));

    always_comb begin
        div_next = wrap ? 32'h0 : div_reg + 32'h1;
        sub_next = sub_reg;
        if (wrap) begin
            sub_next = (sub_reg == MAX_SEC) ? 6'h0 : sub_reg + 6'h1;
        end
        if (restart) begin
            div_next = 32'h0;
            sub_next = 6'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg <= 32'h0;
            sub_reg <= 6'h0;
        end else begin
            div_reg <= div_next;
            sub_reg <= sub_next;
        end
    end

    assign sec_pulse = wrap && !restart;
    assign min_pulse = wrap && !restart && (sub_reg == MAX_SEC);
endmodule
`default_nettype wire

// File: rtc_alarm_assertions.sv
// Checker: bus protocol and register read-back properties of the RTC alarm block
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_checker
    import rtc_alarm_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        irq
);
    logic       dph_rd;
    logic       dph_wr;
    logic       dph_bad;
    logic [7:0] dph_idx;
    logic [7:0] min_sh;
    logic [7:0] year_sh;

    // Data phase bookkeeping and shadows of the alarm minute and year bytes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_rd  <= 1'b0;
            dph_wr  <= 1'b0;
            dph_bad <= 1'b0;
            dph_idx <= 8'h00;
            min_sh  <= 8'h00;
            year_sh <= 8'h00;
        end else begin
            dph_rd  <= hsel && hready && htrans[1] && !hwrite;
            dph_wr  <= hsel && hready && htrans[1] && hwrite;
            dph_bad <= haddr[31:10] != 22'h0;
            dph_idx <= haddr[9:2];
            if (dph_wr && !dph_bad && dph_idx == IDX_ALM_MIN) begin
                min_sh <= hwdata[7:0];
            end
            if (dph_wr && !dph_bad && dph_idx == IDX_ALM_YEAR) begin
                year_sh <= hwdata[7:0];
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_ready_high: assert property (hreadyout) else $error("hreadyout dropped");
    a_resp_okay: assert property (!hresp) else $error("hresp not okay");
    a_rdata_upper: assert property (dph_rd |-> hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_unmapped_zero: assert property (dph_rd && dph_bad |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_min_readback: assert property (
        dph_rd && !dph_bad && dph_idx == IDX_ALM_MIN |-> hrdata[7:0] == min_sh)
        else $error("alarm minute byte read-back wrong");
    a_hour_rsvd: assert property (
        dph_rd && !dph_bad && dph_idx == IDX_ALM_HOUR |-> hrdata[7:5] == 3'h0)
        else $error("field_a reserved bits set");
    a_day_rsvd: assert property (
        dph_rd && !dph_bad && dph_idx == IDX_ALM_DAY |-> hrdata[7:5] == 3'h0)
        else $error("field_b reserved bits set");
    a_month_rsvd: assert property (
        dph_rd && !dph_bad && dph_idx == IDX_ALM_MONTH |-> hrdata[7:4] == 4'h0)
        else $error("field_c reserved bits set");
    a_year_readback: assert property (
        dph_rd && !dph_bad && dph_idx == IDX_ALM_YEAR |-> hrdata[7:0] == year_sh)
        else $error("alarm year byte read-back wrong");
    a_mask_quiets: assert property (
        dph_wr && !dph_bad && dph_idx == IDX_IRQ_MASK && hwdata[2:0] == 3'h0 |=> !irq)
        else $error("irq high with all events masked");

    c_irq_rise: cover property ($rose(irq));
    c_unmapped_read: cover property (dph_rd && dph_bad);
    c_year_write: cover property (dph_wr && dph_idx == IDX_ALM_YEAR);
endmodule
`default_nettype wire

// File: rtc_alarm_tb_top.sv
// Testbench: register, tick, calendar alarm and seconds counter scenarios
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_tb_top
    import rtc_alarm_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    int          mismatches = 0;
    int          tests_run = 0;

    always #50 hclk = ~hclk;

    rtc_alarm_top #(.SNAP_CYC(20), .SEC_CYC(50)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("Compares %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                mismatches++;
                final_report();
            end
            @(posedge hclk);
        end
    endtask

    // One single transfer, then one idle cycle
    task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_ready();
        rd = hrdata;
        @(posedge hclk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, {22'h0, idx, 2'b00}, d, x);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] d);
        bus(1'b0, {22'h0, idx, 2'b00}, 8'h00, d);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        rd(idx, v);
        check(v, exp);
    endtask

    // Irq is sampled between edges, away from register updates
    task automatic wait_irq(input int lim, output logic got);
        int n;
        n = 0;
        @(negedge hclk);
        while (irq !== 1'b1 && n < lim) begin
            n++;
            @(negedge hclk);
        end
        got = irq === 1'b1;
        @(posedge hclk);
    endtask

    task automatic t_fields();
        logic [31:0] v;
        rdc(IDX_ALM_MIN, 32'h0);
        rdc(IDX_ALM_YEAR, 32'h0);
        wr(IDX_ALM_MIN, 8'hfb);
        wr(IDX_ALM_HOUR, 8'hf7);
        wr(IDX_ALM_DAY, 8'hff);
        wr(IDX_ALM_MONTH, 8'hfc);
        wr(IDX_ALM_YEAR, 8'h3f);
        rdc(IDX_ALM_MIN, 32'hfb);
        rdc(IDX_ALM_HOUR, 32'h17);
        rdc(IDX_ALM_DAY, 32'h1f);
        rdc(IDX_ALM_MONTH, 32'h0c);
        rdc(IDX_ALM_YEAR, 32'h3f);
        bus(1'b0, 32'h0000_0400, 8'h00, v);
        check(v, 32'h0);
        wr(IDX_SEC_B3, 8'hff);
        rdc(IDX_SEC_B3, 32'h0);
        $display("test fields done");
    endtask

    task automatic t_seconds();
        logic [31:0] a;
        logic [31:0] b;
        rd(IDX_SEC_B0, a);
        repeat (4) begin
            rd(IDX_SEC_B0, b);
            check(b, a);
        end
        repeat (60) @(posedge hclk);
        rd(IDX_SEC_B0, b);
        check({31'h0, (b - a == 32'h1) || (b - a == 32'h2)}, 32'h1);
        for (int i = 1; i < 4; i++) begin
            rdc(IDX_SEC_B0 + i[7:0], 32'h0);
        end
        $display("test seconds done");
    endtask

    task automatic tick_case(input logic [7:0] mb, input logic [7:0] yb,
                             input logic [2:0] msk, input logic fire, input int lim);
        logic        got;
        logic [31:0] s;
        wr(IDX_ALM_MIN, mb);
        wr(IDX_ALM_YEAR, yb);
        wr(IDX_IRQ_STATUS, 8'h07);
        wr(IDX_IRQ_MASK, {5'h0, msk});
        wait_irq(lim, got);
        check({31'h0, got}, {31'h0, fire});
        rd(IDX_IRQ_STATUS, s);
        check(s & {29'h0, msk}, fire ? {29'h0, msk} : 32'h0);
        wr(IDX_IRQ_MASK, 8'h00);
        wr(IDX_IRQ_STATUS, 8'h07);
        wait_irq(2, got);
        check({31'h0, got}, 32'h0);
        $display("test tick case done");
    endtask

    task automatic set_cal();
        wr(IDX_CAL_SEC, 8'h7a);
        wr(IDX_CAL_MIN, 8'h3b);
        wr(IDX_CAL_HOUR, 8'h17);
        wr(IDX_CAL_DAY, 8'h1f);
        wr(IDX_CAL_MONTH, 8'h0c);
        wr(IDX_CAL_YEAR, 8'h3f);
    endtask

    task automatic t_alarm();
        logic        got;
        logic [31:0] v;
        wr(IDX_IRQ_MASK, 8'h01);
        set_cal();
        wr(IDX_ALM_YEAR, 8'h40);
        wr(IDX_ALM_MIN, 8'h40);
        wr(IDX_ALM_HOUR, 8'h00);
        wr(IDX_ALM_DAY, 8'h01);
        wr(IDX_ALM_MONTH, 8'h01);
        wait_irq(150, got);
        check({31'h0, got}, 32'h0);
        set_cal();
        wr(IDX_ALM_YEAR, 8'h40);
        wait_irq(150, got);
        check({31'h0, got}, 32'h1);
        rd(IDX_CAL_SEC, v);
        check(v, 32'h40);
        rdc(IDX_CAL_MIN, 32'h0);
        rdc(IDX_CAL_HOUR, 32'h0);
        rdc(IDX_CAL_DAY, 32'h1);
        rdc(IDX_CAL_MONTH, 32'h1);
        rdc(IDX_CAL_YEAR, 32'h0);
        wr(IDX_IRQ_MASK, 8'h00);
        wr(IDX_IRQ_STATUS, 8'h07);
        $display("test alarm done");
    endtask

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_fields();
        t_seconds();
        tick_case(8'h00, 8'h80, 3'h2, 1'b1, 60);
        tick_case(8'h00, 8'h00, 3'h2, 1'b0, 120);
        tick_case(8'h40, 8'h80, 3'h2, 1'b0, 120);
        tick_case(8'h80, 8'h80, 3'h4, 1'b1, 3100);
        t_alarm();
        final_report();
    end
endmodule

bind rtc_alarm_top rtc_alarm_checker u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
`default_nettype wire
